// [crsm_core.sv]
/*
 * crsm_core: programmer register set, stack push/pull sequencing and
 * address-map decode of an 8-bit core.
 * assumes: stack memory returns read data the cycle after mem_rd;
 * registers reached over a plain address/strobe port.
 */
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module crsm_core import crsm_pkg::*; #(
    parameter bit LARGE_ROM = 1'b0
) (
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    // register port
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [7:0]  REG_RDATA,
    // stack operation request
    input  wire logic        OP_VALID,
    input  wire logic [3:0]  OP_CODE,
    input  wire logic [15:0] OP_TARGET,
    output logic             OP_BUSY,
    output logic             OP_DONE,
    // stack memory
    output logic             MEM_WR,
    output logic             MEM_RD,
    output logic      [15:0] MEM_ADDR,
    output logic      [7:0]  MEM_WDATA,
    input  wire logic [7:0]  MEM_RDATA,
    // address decode and index helpers
    input  wire logic [15:0] DEC_ADDR,
    output logic      [4:0]  DEC_REGION,
    input  wire logic [7:0]  IDX_OPERAND,
    output logic      [15:0] IDX_ADDR1,
    output logic      [15:0] IDX_ADDR2,
    output logic      [15:0] IDX_DIRECT,
    output logic      [3:0]  BRANCH_COND
);
    crsm_regs_t r_reg;
    crsm_regs_t r_next;
    crsm_regs_t ctl_reg;   // state that reset clears
    crsm_regs_t dat_reg;   // state that reset leaves alone

    // region decode, used for the decode port only
    function automatic crsm_region_t decode(input logic [15:0] a);
        crsm_region_t d;
        d.ram       = (a <= RAM_TOP);
        d.zero_page = (a <= ZERO_PAGE_TOP);
        d.rom       = LARGE_ROM ? (a >= ROM_BASE_LARGE)
                                : (a >= ROM_BASE_SMALL);
        d.special   = (a >= SPECIAL_BASE);
        d.vector    = (a >= VECTOR_BASE);
        return d;
    endfunction

    // stack address from page bit and pointer
    function automatic logic [15:0] stack_addr(input logic pg,
                                               input logic [7:0] sp);
        return {(pg ? PAGE1 : PAGE0), sp};
    endfunction

    // next-state logic
    always_comb begin
        r_next       = r_reg;
        r_next.done  = 1'b0;
        r_next.mem.wr = 1'b0;
        r_next.mem.rd = 1'b0;
        r_next.rst_s1 = 1'b1;
        r_next.rst_s2 = r_reg.rst_s1;
        // register writes
        if (REG_WR && !r_reg.busy) begin
            unique case (REG_ADDR)
                OFS_RESULT:  r_next.result = REG_WDATA;
                OFS_OFFS1:   r_next.offs1  = REG_WDATA;
                OFS_OFFS2:   r_next.offs2  = REG_WDATA;
                OFS_STACK:   r_next.sp     = REG_WDATA;
                OFS_IPLOW:   r_next.ip[7:0]  = REG_WDATA;
                OFS_IPHIGH:  r_next.ip[15:8] = REG_WDATA;
                OFS_FLAGS:   r_next.flags  = REG_WDATA;
                OFS_PAGESEL: r_next.page_sel = REG_WDATA[STACK_PAGE_BIT];
                OFS_VECSEL:  r_next.vec = {8'hff, REG_WDATA};
                default:     r_next.rdata = r_next.rdata;
            endcase
        end
        // register reads, data one cycle later
        if (REG_RD) begin
            unique case (REG_ADDR)
                OFS_RESULT:  r_next.rdata = r_reg.result;
                OFS_OFFS1:   r_next.rdata = r_reg.offs1;
                OFS_OFFS2:   r_next.rdata = r_reg.offs2;
                OFS_STACK:   r_next.rdata = r_reg.sp;
                OFS_IPLOW:   r_next.rdata = r_reg.ip[7:0];
                OFS_IPHIGH:  r_next.rdata = r_reg.ip[15:8];
                OFS_FLAGS:   r_next.rdata = r_reg.flags;
                OFS_PAGESEL: r_next.rdata = {3'h0, r_reg.page_sel, 4'h0};
                OFS_STATUS:  r_next.rdata = {6'h00, r_reg.op != CRSM_OP_NONE,
                                             r_reg.busy};
                OFS_VECSEL:  r_next.rdata = r_reg.vec[7:0];
                default:     r_next.rdata = 8'h00;
            endcase
        end else begin
            r_next.rdata = 8'h00;
        end
        // stack sequencer
        unique case (r_reg.state)
            ST_IDLE: begin
                if (OP_VALID) begin
                    r_next.op     = crsm_op_t'(OP_CODE);
                    r_next.target = OP_TARGET;
                    r_next.busy   = 1'b1;
                    unique case (crsm_op_t'(OP_CODE))
                        CRSM_OP_INTR, CRSM_OP_CALL, CRSM_OP_PUSHR,
                        CRSM_OP_PUSHF: begin
                            r_next.state = ST_PUSH0;
                        end
                        CRSM_OP_RETEV, CRSM_OP_RETCL, CRSM_OP_PULLR,
                        CRSM_OP_PULLF: begin
                            r_next.state    = ST_PULL0;
                            r_next.sp       = r_reg.sp + 8'h01;
                            r_next.mem.rd   = 1'b1;
                            r_next.mem.addr = stack_addr(r_reg.page_sel,
                                                         r_reg.sp + 8'h01);
                        end
                        CRSM_OP_LOADSP: begin
                            r_next.sp   = r_reg.offs1;
                            r_next.busy = 1'b0;
                            r_next.done = 1'b1;
                            r_next.op   = CRSM_OP_NONE;
                        end
                        default: begin
                            r_next.busy = 1'b0;
                            r_next.op   = CRSM_OP_NONE;
                        end
                    endcase
                end
            end
            ST_PUSH0, ST_PUSH1, ST_PUSH2: begin
                r_next.mem.wr   = 1'b1;
                r_next.mem.addr = stack_addr(r_reg.page_sel, r_reg.sp);
                r_next.sp = r_reg.sp - 8'h01;
                if (r_reg.state == ST_PUSH0) begin
                    unique case (r_reg.op)
                        CRSM_OP_PUSHR: r_next.mem.wdata = r_reg.result;
                        CRSM_OP_PUSHF: r_next.mem.wdata = r_reg.flags;
                        default:       r_next.mem.wdata = r_reg.ip[15:8];
                    endcase
                end else if (r_reg.state == ST_PUSH1) begin
                    r_next.mem.wdata = r_reg.ip[7:0];
                end else begin
                    r_next.mem.wdata = r_reg.flags;
                end
                if ((r_reg.state == ST_PUSH0 &&
                     (r_reg.op == CRSM_OP_PUSHR ||
                      r_reg.op == CRSM_OP_PUSHF)) ||
                    (r_reg.state == ST_PUSH1 && r_reg.op == CRSM_OP_CALL) ||
                    r_reg.state == ST_PUSH2) begin
                    r_next.state = ST_IDLE;
                    r_next.busy  = 1'b0;
                    r_next.done  = 1'b1;
                    r_next.op    = CRSM_OP_NONE;
                    if (r_reg.op == CRSM_OP_CALL) begin
                        r_next.ip = r_reg.target;
                    end
                    if (r_reg.op == CRSM_OP_INTR) begin
                        r_next.flags[FLG_IDIS] = 1'b1;
                        r_next.ip = r_reg.target;
                    end
                end else if (r_reg.state == ST_PUSH0) begin
                    r_next.state = ST_PUSH1;
                end else begin
                    r_next.state = ST_PUSH2;
                end
            end
            ST_PULL0, ST_PULL1, ST_PULL2: begin
                // byte stands the cycle after its read strobe
                if (!r_reg.mem.rd) begin
                    unique case (r_reg.op)
                        CRSM_OP_PULLR: r_next.result = MEM_RDATA;
                        CRSM_OP_PULLF: r_next.flags  = MEM_RDATA;
                        CRSM_OP_RETCL: begin
                            if (r_reg.state == ST_PULL0) begin
                                r_next.ip[7:0] = MEM_RDATA;
                            end else begin
                                r_next.ip[15:8] = MEM_RDATA;
                            end
                        end
                        default: begin
                            if (r_reg.state == ST_PULL0) begin
                                r_next.flags = MEM_RDATA;
                            end else if (r_reg.state == ST_PULL1) begin
                                r_next.ip[7:0] = MEM_RDATA;
                            end else begin
                                r_next.ip[15:8] = MEM_RDATA;
                            end
                        end
                    endcase
                    if ((r_reg.state == ST_PULL0 &&
                         (r_reg.op == CRSM_OP_PULLR ||
                          r_reg.op == CRSM_OP_PULLF)) ||
                        (r_reg.state == ST_PULL1 &&
                         r_reg.op == CRSM_OP_RETCL) ||
                        r_reg.state == ST_PULL2) begin
                        r_next.state = ST_IDLE;
                        r_next.busy  = 1'b0;
                        r_next.done  = 1'b1;
                        r_next.op    = CRSM_OP_NONE;
                    end else begin
                        // next read, pointer wraps in page
                        r_next.sp       = r_reg.sp + 8'h01;
                        r_next.mem.rd   = 1'b1;
                        r_next.mem.addr = stack_addr(r_reg.page_sel,
                                                     r_reg.sp + 8'h01);
                        r_next.state    = (r_reg.state == ST_PULL0) ?
                                          ST_PULL1 : ST_PULL2;
                    end
                end
            end
            default: begin
                r_next.state = ST_IDLE;
                r_next.busy  = 1'b0;
            end
        endcase
    end

    // reset flops; their data register copies go unused
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ctl_reg.state    <= ST_IDLE;
            ctl_reg.op       <= CRSM_OP_NONE;
            ctl_reg.result   <= 8'h00;
            ctl_reg.offs1    <= 8'h00;
            ctl_reg.offs2    <= 8'h00;
            ctl_reg.sp       <= 8'h00;
            ctl_reg.flags    <= FLAGS_RST;
            ctl_reg.ip       <= IP_RST;
            ctl_reg.page_sel <= 1'b0;
            ctl_reg.vec      <= 16'hfffe;
            ctl_reg.target   <= 16'h0000;
            ctl_reg.mem      <= '0;
            ctl_reg.busy     <= 1'b0;
            ctl_reg.done     <= 1'b0;
            ctl_reg.rdata    <= 8'h00;
            ctl_reg.rst_s1   <= 1'b0;
            ctl_reg.rst_s2   <= 1'b0;
        end else begin
            ctl_reg <= r_next;
        end
    end

    // pointer and data registers not reset
    always_ff @(posedge CLK_SYS) begin
        dat_reg <= r_next;
    end

    // one view: control from reset flops, data from plain flops
    always_comb begin
        r_reg        = ctl_reg;
        r_reg.result = dat_reg.result;
        r_reg.offs1  = dat_reg.offs1;
        r_reg.offs2  = dat_reg.offs2;
        r_reg.sp     = dat_reg.sp;
    end

    // outputs
    assign REG_RDATA  = r_reg.rdata;
    assign OP_BUSY    = r_reg.busy;
    assign OP_DONE    = r_reg.done;
    assign MEM_WR     = r_reg.mem.wr;
    assign MEM_RD     = r_reg.mem.rd;
    assign MEM_ADDR   = r_reg.mem.addr;
    assign MEM_WDATA  = r_reg.mem.wdata;
    assign DEC_REGION = decode(DEC_ADDR);
    assign IDX_ADDR1  = {8'h00, IDX_OPERAND} + {8'h00, r_reg.offs1};
    assign IDX_ADDR2  = {8'h00, IDX_OPERAND} + {8'h00, r_reg.offs2};
    assign IDX_DIRECT = r_reg.flags[FLG_INDEX] ? {8'h00, r_reg.offs1}
                                               : {8'h00, IDX_OPERAND};
    assign BRANCH_COND = {r_reg.flags[FLG_MSB], r_reg.flags[FLG_RANGE],
                          r_reg.flags[FLG_NULL], r_reg.flags[FLG_BORROW]};

    sequence s_intr_start;
        r_reg.state == ST_PUSH0 && r_reg.op == CRSM_OP_INTR;
    endsequence
    sequence s_push_hi;
        MEM_WR && MEM_WDATA == $past(r_reg.ip[15:8], 1);
    endsequence
    sequence s_push_lo;
        MEM_WR && MEM_WDATA == $past(r_reg.ip[7:0], 2);
    endsequence
    sequence s_push_fl;
        MEM_WR && MEM_WDATA == $past(r_reg.flags, 3);
    endsequence
    AST_INTR_ORDER: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_intr_start |=> s_push_hi ##1 s_push_lo ##1 s_push_fl)
        else $error("interrupt push order wrong");
    AST_INTR_SP: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (r_reg.state == ST_PUSH0 && r_reg.op == CRSM_OP_INTR)
        |=> ##2 (r_reg.sp == $past(r_reg.sp, 3) - 8'h03))
        else $error("interrupt push did not drop pointer by three");
    AST_INTR_IDIS: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (r_reg.state == ST_PUSH2 && r_reg.op == CRSM_OP_INTR)
        |=> r_reg.flags[FLG_IDIS] && r_reg.ip == $past(r_reg.target))
        else $error("interrupt entry missed flag or vector");
    AST_PAGE: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        MEM_WR |-> MEM_ADDR[15:8] == (r_reg.page_sel ? PAGE1 : PAGE0))
        else $error("stack address page wrong");
    AST_CALL: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (r_reg.state == ST_PUSH0 && r_reg.op == CRSM_OP_CALL)
        |=> ##1 OP_DONE && r_reg.ip == $past(r_reg.target, 2))
        else $error("call did not finish after two pushes");
    AST_LOADSP: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (r_reg.state == ST_IDLE && OP_VALID && OP_CODE == CRSM_OP_LOADSP)
        |=> r_reg.sp == $past(r_reg.offs1))
        else $error("pointer load failed");
    AST_IDX1: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (REG_WR && !OP_BUSY && REG_ADDR == OFS_OFFS1)
        |=> IDX_ADDR1 == 16'(IDX_OPERAND) + 16'($past(REG_WDATA)))
        else $error("index one sum wrong");
    AST_ROM: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        DEC_ADDR >= ROM_BASE_SMALL |-> DEC_REGION[2])
        else $error("rom not decoded");
    AST_PUSHR: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (r_reg.state == ST_PUSH0 && r_reg.op == CRSM_OP_PUSHR)
        |=> MEM_WR && MEM_WDATA == $past(r_reg.result))
        else $error("result push wrong data");
endmodule

// [crsm_pkg.sv]
/*
 * crsm_pkg: constants and carriers for the core register set, stack
 * sequencing and address map block.
 * assumes: one 100 MHz system clock; used by crsm_core and tb.
 */
package crsm_pkg;
    // clock and documented times
    localparam int  CLK_MHZ         = 100;
    localparam int  RESET_LOW_NS    = 2000;
    localparam int  RESET_LOW_CYC   = (RESET_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int  MIN_INSTR_NS    = 2000;
    localparam int  MIN_INSTR_CYC   = (MIN_INSTR_NS * CLK_MHZ) / 1000;

    // address map
    localparam logic [15:0] ROM_BASE_SMALL = 16'hf000;
    localparam logic [15:0] ROM_BASE_LARGE = 16'he800;
    localparam logic [15:0] SPECIAL_BASE   = 16'hff00;
    localparam logic [15:0] VECTOR_BASE    = 16'hfff4;
    localparam logic [15:0] ZERO_PAGE_TOP  = 16'h00ff;
    localparam logic [15:0] RAM_TOP        = 16'h008f;
    localparam logic [15:0] STACK_PAGE_REG = 16'h00ff;
    localparam int          STACK_PAGE_BIT = 4;
    localparam logic [7:0]  PAGE0          = 8'h00;
    localparam logic [7:0]  PAGE1          = 8'h01;

    // register port offsets
    localparam logic [3:0] OFS_RESULT  = 4'h0;
    localparam logic [3:0] OFS_OFFS1   = 4'h1;
    localparam logic [3:0] OFS_OFFS2   = 4'h2;
    localparam logic [3:0] OFS_STACK   = 4'h3;
    localparam logic [3:0] OFS_IPLOW   = 4'h4;
    localparam logic [3:0] OFS_IPHIGH  = 4'h5;
    localparam logic [3:0] OFS_FLAGS   = 4'h6;
    localparam logic [3:0] OFS_PAGESEL = 4'h7;
    localparam logic [3:0] OFS_STATUS  = 4'h8;
    localparam logic [3:0] OFS_VECSEL  = 4'h9;

    // flag word bit positions
    localparam int FLG_BORROW = 0;
    localparam int FLG_NULL   = 1;
    localparam int FLG_IDIS   = 2;
    localparam int FLG_INDEX  = 5;
    localparam int FLG_RANGE  = 6;
    localparam int FLG_MSB    = 7;

    // reset values of resettable state
    localparam logic [7:0]  FLAGS_RST = 8'h04;
    localparam logic [15:0] IP_RST    = 16'h0000;

    // stack operations
    typedef enum logic [3:0] {
        CRSM_OP_NONE   = 4'h0,
        CRSM_OP_INTR   = 4'h1,
        CRSM_OP_RETEV  = 4'h2,
        CRSM_OP_CALL   = 4'h3,
        CRSM_OP_RETCL  = 4'h4,
        CRSM_OP_PUSHR  = 4'h5,
        CRSM_OP_PULLR  = 4'h6,
        CRSM_OP_PUSHF  = 4'h7,
        CRSM_OP_PULLF  = 4'h8,
        CRSM_OP_LOADSP = 4'h9
    } crsm_op_t;

    // sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b0000001,
        ST_PUSH0 = 7'b0000010,
        ST_PUSH1 = 7'b0000100,
        ST_PUSH2 = 7'b0001000,
        ST_PULL0 = 7'b0010000,
        ST_PULL1 = 7'b0100000,
        ST_PULL2 = 7'b1000000
    } crsm_state_t;

    // memory map region decode result
    typedef struct packed {
        logic ram;
        logic zero_page;
        logic rom;
        logic special;
        logic vector;
    } crsm_region_t;

    // one stack memory request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } crsm_mem_t;

    // whole module state
    typedef struct packed {
        crsm_state_t state;
        crsm_op_t    op;
        logic [7:0]  result;
        logic [7:0]  offs1;
        logic [7:0]  offs2;
        logic [7:0]  sp;
        logic [15:0] ip;
        logic [7:0]  flags;
        logic        page_sel;
        logic [15:0] vec;
        logic [15:0] target;
        crsm_mem_t   mem;
        logic        busy;
        logic        done;
        logic [7:0]  rdata;
        logic        rst_s1;
        logic        rst_s2;
    } crsm_regs_t;
endpackage

// [crsm_mem_model.sv]
/*
 * crsm_mem_model: stack RAM standing behind the core, pages 00 and 01.
 * assumes: read data is wanted in the cycle after the read strobe only.
 */
`timescale 1ns/1ps
module crsm_mem_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // memory port
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata
);
    logic [7:0] mem_reg [0:511];

    always_ff @(posedge clk) begin
        if (wr) begin
            mem_reg[addr[8:0]] <= wdata;
        end
    end

    // read data stands one cycle, then toggles so stale use shows
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 8'h00;
        end else if (rd) begin
            rdata <= mem_reg[addr[8:0]];
        end else begin
            rdata <= ~rdata;
        end
    end
endmodule

// [tb.sv]
/*
 * tb: self-checking bench for crsm_core with a stack RAM model.
 * assumes: small ROM variant; registers reached over the strobe port.
 */
`timescale 1ns/1ps
module tb;
    import crsm_pkg::*;
    logic        clk_sys, rst_b, reg_wr, reg_rd, op_valid, mem_wr, mem_rd;
    logic [3:0]  reg_addr, op_code, branch_cond;
    logic [7:0]  reg_wdata, reg_rdata, mem_wdata, mem_rdata, idx_operand;
    logic [15:0] op_target, mem_addr, dec_addr;
    logic [15:0] idx_addr1, idx_addr2, idx_direct;
    logic        op_busy, op_done;
    logic [4:0]  dec_region;
    logic [23:0] wq[$];
    int          err_count, checks;

    crsm_core crsm_core_inst (.CLK_SYS(clk_sys), .RST_B(rst_b),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .OP_VALID(op_valid),
        .OP_CODE(op_code), .OP_TARGET(op_target), .OP_BUSY(op_busy),
        .OP_DONE(op_done), .MEM_WR(mem_wr), .MEM_RD(mem_rd),
        .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
        .MEM_RDATA(mem_rdata), .DEC_ADDR(dec_addr),
        .DEC_REGION(dec_region), .IDX_OPERAND(idx_operand),
        .IDX_ADDR1(idx_addr1), .IDX_ADDR2(idx_addr2),
        .IDX_DIRECT(idx_direct), .BRANCH_COND(branch_cond));
    crsm_mem_model crsm_mem_model_inst (.clk(clk_sys), .rst_b(rst_b),
        .wr(mem_wr), .rd(mem_rd), .addr(mem_addr), .wdata(mem_wdata),
        .rdata(mem_rdata));

    // clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // record every stack write
    always @(posedge clk_sys) begin
        if (mem_wr === 1'b1) begin
            wq.push_back({mem_addr, mem_wdata});
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_wr(input logic [15:0] a, input logic [7:0] d);
        logic [23:0] e;
        e = '0;
        if (wq.size() > 0) begin
            e = wq.pop_front();
        end
        chk(e, {a, d});
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk({16'h0, reg_rdata}, {16'h0, exp});
    endtask

    // one stack operation, waits for its done pulse
    task automatic op(input crsm_op_t c, input logic [15:0] t);
        int n;
        @(posedge clk_sys);
        op_valid <= 1'b1;
        op_code <= c;
        op_target <= t;
        @(posedge clk_sys);
        op_valid <= 1'b0;
        n = 0;
        #1;
        if (c != CRSM_OP_LOADSP) begin
            chk(24'(op_busy), 24'h1);
        end
        while (op_done !== 1'b1 && n < 30) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        // let the recorder see the last stack write
        @(posedge clk_sys);
        #1;
        chk(24'(n < 30), 24'h1);
    endtask

    task automatic t_regs;
        rd(OFS_FLAGS, FLAGS_RST);
        rd(OFS_IPLOW, IP_RST[7:0]);
        rd(OFS_IPHIGH, IP_RST[15:8]);
        rd(OFS_PAGESEL, 8'h00);
        rd(OFS_STATUS, 8'h00);
        rd(4'ha, 8'h00);
        wr(4'ha, 8'h5a);
        wr(OFS_RESULT, 8'hc3);
        rd(OFS_RESULT, 8'hc3);
        $display("regs test done");
    endtask

    task automatic t_decode;
        logic [20:0] tb_map [13] = '{
            {16'h0000, 5'h18}, {16'h008f, 5'h18}, {16'h0090, 5'h08},
            {16'h00ff, 5'h08}, {16'h0100, 5'h00}, {16'he800, 5'h00},
            {16'hefff, 5'h00}, {16'hf000, 5'h04}, {16'hfeff, 5'h04},
            {16'hff00, 5'h06}, {16'hfff3, 5'h06}, {16'hfff4, 5'h07},
            {16'hffff, 5'h07}};
        for (int i = 0; i < 13; i++) begin
            @(posedge clk_sys);
            dec_addr <= tb_map[i][20:5];
            #1;
            chk({19'h0, dec_region}, {19'h0, tb_map[i][4:0]});
        end
        $display("decode test done");
    endtask

    task automatic t_index;
        wr(OFS_OFFS1, 8'h10);
        wr(OFS_OFFS2, 8'h20);
        wr(OFS_FLAGS, 8'h61);
        @(posedge clk_sys);
        idx_operand <= 8'h05;
        #1;
        chk({8'h0, idx_addr1}, 24'h000015);
        chk({8'h0, idx_addr2}, 24'h000025);
        chk({8'h0, idx_direct}, 24'h000010);
        chk({20'h0, branch_cond}, 24'h5);
        wr(OFS_FLAGS, 8'h82);
        #1;
        chk({20'h0, branch_cond}, 24'ha);
        chk({8'h0, idx_direct}, 24'h000005);
        $display("index test done");
    endtask

    task automatic t_intr;
        wr(OFS_OFFS1, 8'h8f);
        op(CRSM_OP_LOADSP, 16'h0000);
        rd(OFS_STACK, 8'h8f);
        wr(OFS_IPLOW, 8'h34);
        wr(OFS_IPHIGH, 8'h12);
        wr(OFS_FLAGS, 8'h00);
        op(CRSM_OP_INTR, 16'hfffc);
        chk_wr(16'h008f, 8'h12);
        chk_wr(16'h008e, 8'h34);
        chk_wr(16'h008d, 8'h00);
        chk(24'(wq.size()), 24'h0);
        rd(OFS_STACK, 8'h8c);
        rd(OFS_FLAGS, 8'h04);
        rd(OFS_IPLOW, 8'hfc);
        rd(OFS_IPHIGH, 8'hff);
        op(CRSM_OP_RETEV, 16'h0000);
        rd(OFS_FLAGS, 8'h00);
        rd(OFS_IPLOW, 8'h34);
        rd(OFS_IPHIGH, 8'h12);
        rd(OFS_STACK, 8'h8f);
        $display("interrupt test done");
    endtask

    // mid-run reset: control state clears, data registers keep
    task automatic t_reset;
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (RESET_LOW_CYC) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(OFS_FLAGS, FLAGS_RST);
        rd(OFS_IPHIGH, IP_RST[15:8]);
        rd(OFS_STACK, 8'h8f);
        rd(OFS_RESULT, 8'hc3);
        $display("reset test done");
    endtask

    task automatic t_stack;
        wr(OFS_PAGESEL, 8'h10);
        wr(OFS_OFFS1, 8'h00);
        op(CRSM_OP_LOADSP, 16'h0000);
        wr(OFS_IPLOW, 8'h78);
        wr(OFS_IPHIGH, 8'h56);
        op(CRSM_OP_CALL, 16'h0123);
        chk_wr(16'h0100, 8'h56);
        chk_wr(16'h01ff, 8'h78);
        chk(24'(wq.size()), 24'h0);
        rd(OFS_STACK, 8'hfe);
        rd(OFS_IPLOW, 8'h23);
        op(CRSM_OP_RETCL, 16'h0000);
        rd(OFS_IPLOW, 8'h78);
        rd(OFS_IPHIGH, 8'h56);
        rd(OFS_STACK, 8'h00);
        wr(OFS_RESULT, 8'ha5);
        op(CRSM_OP_PUSHR, 16'h0000);
        chk_wr(16'h0100, 8'ha5);
        wr(OFS_RESULT, 8'h00);
        op(CRSM_OP_PULLR, 16'h0000);
        rd(OFS_RESULT, 8'ha5);
        wr(OFS_FLAGS, 8'h81);
        op(CRSM_OP_PUSHF, 16'h0000);
        chk_wr(16'h0100, 8'h81);
        wr(OFS_FLAGS, 8'h00);
        op(CRSM_OP_PULLF, 16'h0000);
        rd(OFS_FLAGS, 8'h81);
        $display("stack test done");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog, well past the expected few hundred cycles
    initial begin
        #200000;
        err_count++;
        stop_test();
    end

    // main sequence
    initial begin
        {rst_b, reg_wr, reg_rd, op_valid} = '0;
        {reg_addr, op_code, reg_wdata, idx_operand} = '0;
        {op_target, dec_addr} = '0;
        err_count = 0;
        checks = 0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_regs();
        t_decode();
        t_index();
        t_intr();
        t_reset();
        t_stack();
        stop_test();
    end
endmodule
